// file: rtl/crd_readback.sv
`timescale 1ns/100ps
module crd_readback
  import crd_pkg::*;
(
  input  wire logic                  sys_clk,                // Clock
  input  wire logic                  sys_rst,                // Sync reset
  input  wire logic                  cmd_valid,              // Command strobe
  input  wire logic [CRD_ADDR_W-1:0] cmd_addr,               // Command addr
  input  wire logic                  rd_strobe,              // Parameter req
  input  wire logic [CRD_CHAR_W-1:0] blue_y_characteristic,  // Blue y value
  input  wire logic [CRD_CHAR_W-1:0] extra_x_characteristic, // Extra x value
  input  wire logic [CRD_CHAR_W-1:0] extra_y_characteristic, // Extra y value
  input  wire logic [CRD_ID_W-1:0]   supplier_identifier,    // Block supplier
  input  wire logic [CRD_ID_W-1:0]   module_identifier,      // Block module
  output logic      [CRD_WORD_W-1:0] rd_word,                // Returned word
  output logic                       rd_valid,               // Word pulse
  output logic                       rd_exit,                // Exit byte flag
  output logic                       read_armed,             // Read active
  output logic      [CRD_POS_W-1:0]  ddb_pos                 // Next byte pos
);

  crd_state_t            state;
  crd_state_t            next_state;
  crd_char_sel_t         char_sel;
  crd_char_sel_t         next_char_sel;
  logic                  hit_blue_y;
  logic                  hit_extra_x;
  logic                  hit_extra_y;
  logic                  hit_start;
  logic                  hit_cont;
  logic                  take_read;
  logic [CRD_BYTE_W-1:0] char_byte;
  logic [CRD_BYTE_W-1:0] ddb_byte;
  logic [CRD_BYTE_W-1:0] next_byte;

  // Command decode
  assign hit_blue_y  = cmd_valid && crd_is_cmd(cmd_addr, CRD_BLUE_Y_HIGH_BITS);
  assign hit_extra_x = cmd_valid
                       && crd_is_cmd(cmd_addr, CRD_EXTRA_X_HIGH_BITS);
  assign hit_extra_y = cmd_valid
                       && crd_is_cmd(cmd_addr, CRD_EXTRA_Y_HIGH_BITS);
  assign hit_start   = cmd_valid
                       && crd_is_cmd(cmd_addr, CRD_DESCRIPTOR_START_READ);
  assign hit_cont    = cmd_valid
                       && crd_is_cmd(cmd_addr, CRD_DESCRIPTOR_CONTINUE_READ);

  // A parameter is served only with no command in the same cycle
  assign take_read = rd_strobe && !cmd_valid && (state != CRD_ST_IDLE);

  // Next state and characteristic selection
  always_comb begin
    next_state    = state;
    next_char_sel = char_sel;
    if (cmd_valid) begin
      next_state = CRD_ST_IDLE;
      if (hit_blue_y) begin
        next_state    = CRD_ST_CHAR;
        next_char_sel = CRD_SEL_BLUE_Y;
      end else if (hit_extra_x) begin
        next_state    = CRD_ST_CHAR;
        next_char_sel = CRD_SEL_EXTRA_X;
      end else if (hit_extra_y) begin
        next_state    = CRD_ST_CHAR;
        next_char_sel = CRD_SEL_EXTRA_Y;
      end else if (hit_start || hit_cont) begin
        next_state = CRD_ST_DDB;
      end
    end
  end

  // Read state register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state      <= CRD_ST_IDLE;
      read_armed <= 1'b0;
    end else begin
      state      <= next_state;
      read_armed <= (next_state != CRD_ST_IDLE);
    end
  end

  // Characteristic selection register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      char_sel <= CRD_SEL_BLUE_Y;
    end else begin
      char_sel <= next_char_sel;
    end
  end

  // Descriptor position, counts bytes already delivered, holds at CRD_POS_DONE
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ddb_pos <= CRD_POS_RST;
    end else if (hit_start) begin
      ddb_pos <= CRD_POS_RST;
    end else if (take_read && state == CRD_ST_DDB
                 && ddb_pos != CRD_POS_DONE) begin
      ddb_pos <= ddb_pos + 3'h1;
    end
  end

  crd_char_slice u_char_slice (
    .blue_y_characteristic  (blue_y_characteristic),
    .extra_x_characteristic (extra_x_characteristic),
    .extra_y_characteristic (extra_y_characteristic),
    .sel                    (char_sel),
    .high_bits              (char_byte)
  );

  crd_ddb_source u_ddb_source (
    .supplier_identifier (supplier_identifier),
    .module_identifier   (module_identifier),
    .pos                 (ddb_pos),
    .ddb_byte            (ddb_byte)
  );

  assign next_byte = (state == CRD_ST_DDB) ? ddb_byte : char_byte;

  // Returned parameter word
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rd_word  <= {CRD_UPPER_BYTE, CRD_BYTE_RST};
      rd_valid <= 1'b0;
      rd_exit  <= 1'b0;
    end else begin
      rd_valid <= take_read;
      if (take_read) begin
        rd_word <= {CRD_UPPER_BYTE, next_byte};
        rd_exit <= (state == CRD_ST_DDB) && (ddb_pos >= CRD_POS_EXIT);
      end else begin
        rd_exit <= 1'b0;
      end
    end
  end

endmodule

// file: rtl/crd_pkg.sv
package crd_pkg;

  // Widths of the command port, input values, returned words and descriptor position
  localparam int unsigned CRD_ADDR_W  = 16;
  localparam int unsigned CRD_BYTE_W  = 8;
  localparam int unsigned CRD_WORD_W  = 16;
  localparam int unsigned CRD_CHAR_W  = 10;
  localparam int unsigned CRD_ID_W    = 16;
  localparam int unsigned CRD_POS_W   = 3;

  // Command addresses; the upper byte is the command code
  localparam logic [15:0] CRD_BLUE_Y_HIGH_BITS         = 16'h7c00;
  localparam logic [15:0] CRD_EXTRA_X_HIGH_BITS        = 16'h7d00;
  localparam logic [15:0] CRD_EXTRA_Y_HIGH_BITS        = 16'h7e00;
  localparam logic [15:0] CRD_DESCRIPTOR_START_READ    = 16'ha100;
  localparam logic [15:0] CRD_DESCRIPTOR_CONTINUE_READ = 16'ha800;

  // Slice of a characteristic that is returned
  localparam int unsigned CRD_CHAR_MSB = 9;
  localparam int unsigned CRD_CHAR_LSB = 2;

  // Descriptor block layout, one position per returned byte
  localparam logic [2:0] CRD_POS_SUP_LO = 3'h0;
  localparam logic [2:0] CRD_POS_SUP_HI = 3'h1;
  localparam logic [2:0] CRD_POS_MOD_LO = 3'h2;
  localparam logic [2:0] CRD_POS_MOD_HI = 3'h3;
  localparam logic [2:0] CRD_POS_EXIT   = 3'h4;
  localparam logic [2:0] CRD_POS_DONE   = 3'h5;
  localparam logic [7:0] CRD_EXIT_CODE  = 8'hff;

  // Values after reset
  localparam logic [7:0] CRD_UPPER_BYTE = 8'h00;
  localparam logic [7:0] CRD_BYTE_RST   = 8'h00;
  localparam logic [2:0] CRD_POS_RST    = 3'h0;

  typedef enum logic [1:0] {
    CRD_ST_IDLE = 2'b00,
    CRD_ST_CHAR = 2'b01,
    CRD_ST_DDB  = 2'b11
  } crd_state_t;

  typedef enum logic [1:0] {
    CRD_SEL_BLUE_Y  = 2'b00,
    CRD_SEL_EXTRA_X = 2'b01,
    CRD_SEL_EXTRA_Y = 2'b10
  } crd_char_sel_t;

  // Command code match on the upper address byte
  function automatic logic crd_is_cmd(input logic [15:0] addr,
                                      input logic [15:0] code);
    crd_is_cmd = (addr[15:8] == code[15:8]);
  endfunction

endpackage

// file: rtl/crd_char_slice.sv
`timescale 1ns/100ps
module crd_char_slice
  import crd_pkg::*;
(
  input  wire logic [CRD_CHAR_W-1:0] blue_y_characteristic,  // Blue y
  input  wire logic [CRD_CHAR_W-1:0] extra_x_characteristic, // Extra x
  input  wire logic [CRD_CHAR_W-1:0] extra_y_characteristic, // Extra y
  input  wire crd_char_sel_t         sel,                    // Selection
  output logic      [CRD_BYTE_W-1:0] high_bits               // Bits 9..2
);

  // Upper eight bits, bit 9 lands in bit 7
  always_comb begin
    case (sel)
      CRD_SEL_BLUE_Y: begin
        high_bits = blue_y_characteristic[CRD_CHAR_MSB:CRD_CHAR_LSB];
      end
      CRD_SEL_EXTRA_X: begin
        high_bits = extra_x_characteristic[CRD_CHAR_MSB:CRD_CHAR_LSB];
      end
      CRD_SEL_EXTRA_Y: begin
        high_bits = extra_y_characteristic[CRD_CHAR_MSB:CRD_CHAR_LSB];
      end
      default: begin
        high_bits = CRD_BYTE_RST;
      end
    endcase
  end

endmodule

// file: rtl/crd_ddb_source.sv
`timescale 1ns/100ps
module crd_ddb_source
  import crd_pkg::*;
(
  input  wire logic [CRD_ID_W-1:0]   supplier_identifier, // Block supplier
  input  wire logic [CRD_ID_W-1:0]   module_identifier,   // Block module
  input  wire logic [CRD_POS_W-1:0]  pos,                 // Byte position
  output logic      [CRD_BYTE_W-1:0] ddb_byte             // Byte at pos
);

  always_comb begin
    case (pos)
      CRD_POS_SUP_LO: ddb_byte = supplier_identifier[7:0];
      CRD_POS_SUP_HI: ddb_byte = supplier_identifier[15:8];
      CRD_POS_MOD_LO: ddb_byte = module_identifier[7:0];
      CRD_POS_MOD_HI: ddb_byte = module_identifier[15:8];
      default:        ddb_byte = CRD_EXIT_CODE;
    endcase
  end

endmodule

// file: tb/crd_readback_chk.sv
`timescale 1ns/100ps
module crd_readback_chk (
  input wire logic        sys_clk,    // Clock
  input wire logic        sys_rst,    // Reset
  input wire logic        cmd_valid,  // Command
  input wire logic [15:0] cmd_addr,   // Address
  input wire logic        rd_strobe,  // Request
  input wire logic [15:0] rd_word,    // Word
  input wire logic        rd_valid,   // Pulse
  input wire logic        rd_exit,    // Exit
  input wire logic        read_armed, // Armed
  input wire logic [2:0]  ddb_pos     // Position
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  // Request that the block must take
  wire take = rd_strobe && !cmd_valid && read_armed;
  wire start = cmd_valid && cmd_addr[15:8] == 8'ha1;
  a_answer_next: assert property (take |=> rd_valid)
    else $error("request not answered");
  a_no_spurious: assert property (rd_valid |-> $past(take))
    else $error("word without request");
  a_upper_zero: assert property (rd_valid |-> rd_word[15:8] == 8'h00)
    else $error("upper byte not zero");
  a_exit_byte: assert property (rd_exit |-> rd_valid
    && rd_word[7:0] == 8'hff)
    else $error("exit flag without ff");
  a_exit_last: assert property (rd_exit |-> ddb_pos == 3'h5)
    else $error("exit before block end");
  a_start_rewind: assert property (start |=> read_armed
    && ddb_pos == 3'h0)
    else $error("start did not rewind");
  a_pos_kept: assert property (cmd_valid && !start |=> $stable(ddb_pos))
    else $error("position lost");
  a_pos_step: assert property ($changed(ddb_pos) && !$past(cmd_valid)
    && !$past(sys_rst) |-> rd_valid && ddb_pos == $past(ddb_pos) + 3'h1)
    else $error("position skipped");
  a_refuse_both: assert property (cmd_valid && rd_strobe |=> !rd_valid)
    else $error("collided request answered");
  c_exit: cover property (rd_exit);
  c_resume: cover property (cmd_valid && cmd_addr[15:8] == 8'ha8 ##3 rd_valid);
  c_refused: cover property (rd_strobe && !read_armed);
endmodule

bind crd_readback crd_readback_chk u_chk (.sys_clk, .sys_rst, .cmd_valid,
  .cmd_addr, .rd_strobe, .rd_word, .rd_valid, .rd_exit, .read_armed, .ddb_pos);

// file: tb/crd_host_model.sv
`timescale 1ns/100ps
module crd_host_model (
  input  wire logic        sys_clk,   // Clock
  input  wire logic [15:0] rd_word,   // Returned word
  input  wire logic        rd_valid,  // Word pulse
  input  wire logic        rd_exit,   // Exit flag
  output logic             cmd_valid, // Command strobe
  output logic      [15:0] cmd_addr,  // Command address
  output logic             rd_strobe  // Parameter request
);
  // Idle bus at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_addr = 16'h0000;
    rd_strobe = 1'b0;
  end
  // One-cycle command; address inverted once released
  task automatic send_cmd(input logic [15:0] a);
    @(negedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_addr <= a;
    @(negedge sys_clk);
    cmd_valid <= 1'b0;
    cmd_addr <= ~a;
  endtask
  // One request; answer is looked at in its single valid cycle
  task automatic read_byte(output logic [15:0] w, output logic x, v);
    @(negedge sys_clk);
    rd_strobe <= 1'b1;
    @(negedge sys_clk);
    rd_strobe <= 1'b0;
    w = rd_word;
    x = rd_exit;
    v = rd_valid;
  endtask
endmodule

// file: tb/tb_crd_readback.sv
`timescale 1ns/100ps
module tb_crd_readback;
  import crd_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [9:0] chv [3] = '{10'h2b5, 10'h1ca, 10'h3f3};
  logic [15:0] cmds [3] = '{CRD_BLUE_Y_HIGH_BITS, CRD_EXTRA_X_HIGH_BITS,
                            CRD_EXTRA_Y_HIGH_BITS};
  logic [15:0] sup = 16'h5a3c;
  logic [15:0] mdl = 16'hc3e1;
  logic [7:0] exb [5];
  logic cmd_valid, rd_strobe, rd_valid, rd_exit, read_armed, x, v;
  logic [15:0] cmd_addr, rd_word, w;
  logic [2:0] ddb_pos;
  int mismatches = 0;
  int compares = 0;
  always #10 sys_clk = ~sys_clk;
  crd_readback u_dut (.sys_clk, .sys_rst, .cmd_valid, .cmd_addr, .rd_strobe,
    .blue_y_characteristic(chv[0]), .extra_x_characteristic(chv[1]),
    .extra_y_characteristic(chv[2]), .supplier_identifier(sup),
    .module_identifier(mdl), .rd_word, .rd_valid, .rd_exit, .read_armed,
    .ddb_pos);
  crd_host_model u_host (.sys_clk, .rd_word, .rd_valid, .rd_exit, .cmd_valid,
    .cmd_addr, .rd_strobe);
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  // One answered read with its byte and exit flag
  task automatic rd(logic [7:0] e, logic ex);
    u_host.read_byte(w, x, v);
    chk("rd_valid", 16'h1, 16'(v));
    chk("rd_word", {8'h00, e}, w);
    chk("rd_exit", 16'(ex), 16'(x));
  endtask
  task automatic tally_and_finish;
    if (mismatches == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    exb = '{sup[7:0], sup[15:8], mdl[7:0], mdl[15:8], CRD_EXIT_CODE};
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    sys_rst <= 1'b0;
    @(negedge sys_clk);
    chk("ddb_pos", 16'h0, 16'(ddb_pos));
    chk("read_armed", 16'h0, 16'(read_armed));
    // Each characteristic command
    for (int i = 0; i < 3; i++) begin
      u_host.send_cmd(cmds[i]);
      rd(chv[i][9:2], 1'b0);
    end
    // Whole block, then exit code repeats
    u_host.send_cmd(CRD_DESCRIPTOR_START_READ);
    for (int i = 0; i < 6; i++)
      rd(exb[i < 5 ? i : 4], i >= 4);
    // Packet of three, abandoned, then resumed
    u_host.send_cmd(CRD_DESCRIPTOR_START_READ);
    for (int i = 0; i < 3; i++)
      rd(exb[i], 1'b0);
    u_host.send_cmd(CRD_BLUE_Y_HIGH_BITS);
    rd(chv[0][9:2], 1'b0);
    chk("ddb_pos", 16'h3, 16'(ddb_pos));
    u_host.send_cmd(CRD_DESCRIPTOR_CONTINUE_READ);
    rd(exb[3], 1'b0);
    rd(exb[4], 1'b1);
    // Request together with a command is ignored
    fork
      u_host.send_cmd(CRD_EXTRA_X_HIGH_BITS);
      u_host.read_byte(w, x, v);
    join
    chk("rd_valid", 16'h0, 16'(v));
    rd(chv[1][9:2], 1'b0);
    // Unknown code disarms and keeps position
    u_host.send_cmd(16'h1200);
    u_host.read_byte(w, x, v);
    chk("rd_valid", 16'h0, 16'(v));
    chk("ddb_pos", 16'h5, 16'(ddb_pos));
    tally_and_finish();
  end
endmodule
